//--- rtl/aas_core.sv
// Execution datapath: pointer offset add, sums, masks and signed shift
//
// Operation
// - pointer add sign-extends 6-bit literal onto pointer
// - pointer wraps modulo 16 bits, flags untouched
// - literal sum adds 8-bit literal into accumulator
// - register sum adds accumulator and file register
// - target bit 0 accumulator, 1 file register
// - sum with overflow adds overflow-out flag too
// - literal mask ANDs literal, only null flag
// - register mask ANDs file, routes, null flag
// - signed shift right, bit 0 to overflow-out
// - shift keeps bit 7, bits 7:1 to 6:0
// - pointer add decodes 11 0001 0nkk, one cycle
`timescale 1ns/10ps
module aas_core (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       instr_valid_i,
  input  wire logic [aas_pkg::WORD_W-1:0] instr_i,
  input  wire logic                       acc_load_i,
  input  wire logic [7:0]                 acc_load_data_i,
  input  wire logic                       file_load_i,
  input  wire logic [6:0]                 file_load_addr_i,
  input  wire logic [7:0]                 file_load_data_i,
  input  wire logic                       ptr_load_i,
  input  wire logic                       ptr_load_sel_i,
  input  wire logic [15:0]                ptr_load_data_i,
  input  wire logic [6:0]                 file_peek_addr_i,
  output logic [7:0]                      acc_o,
  output aas_pkg::aas_flags_t             flags_o,
  output logic [15:0]                     indirect_pointer0_o,
  output logic [15:0]                     indirect_pointer1_o,
  output logic [7:0]                      file_peek_o,
  output logic                            done_o,
  output logic                            illegal_o
);
  import aas_pkg::*;

  // ------------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------------
  logic [7:0]    acc;
  aas_flags_t    flags;
  logic [15:0]   indirect_pointer [PTR_N];
  logic [7:0]    file_q [FILE_N];
  logic [7:0]    file_peek;
  logic          done;
  logic          illegal;

  aas_instr_t    dec;
  aas_sum_t      add;
  logic          exec_en;
  logic [7:0]    fsrc;
  logic [7:0]    add_b;
  logic          add_cin;
  logic [15:0]   ptr_off;
  logic [7:0]    next_result;
  aas_flags_t    next_flags;
  logic          wr_acc;
  logic          wr_file;

  aas_decode u_decode (
    .instr_i (instr_i),
    .dec_o   (dec)
  );

  // Operand selection feeding the shared adder
  assign exec_en = instr_valid_i && (dec.op != OP_NONE);
  assign fsrc    = file_q[dec.faddr];
  assign add_b   = (dec.op == OP_LIT_SUM) ? dec.lit : fsrc;
  assign add_cin = (dec.op == OP_REG_SUM_C) && flags.overflow_out;
  assign ptr_off = {{10{dec.off[5]}}, dec.off};

  aas_adder u_adder (
    .a_i   (acc),
    .b_i   (add_b),
    .cin_i (add_cin),
    .res_o (add)
  );

  // ------------------------------------------------------------------
  // Result, flag and destination selection
  // ------------------------------------------------------------------
  always_comb begin
    next_result = 8'h00;
    next_flags  = flags;
    wr_acc      = 1'b0;
    wr_file     = 1'b0;
    unique case (dec.op)
      OP_LIT_SUM: begin
        next_result = add.sum;
        wr_acc      = 1'b1;
        next_flags  = '{add.carry, add.half, add.sum == 8'h00};
      end
      OP_REG_SUM, OP_REG_SUM_C: begin
        next_result = add.sum;
        wr_acc      = !dec.dest;
        wr_file     = dec.dest;
        next_flags  = '{add.carry, add.half, add.sum == 8'h00};
      end
      OP_LIT_MASK: begin
        next_result            = acc & dec.lit;
        wr_acc                 = 1'b1;
        next_flags.result_null = (next_result == 8'h00);
      end
      OP_REG_MASK: begin
        next_result            = acc & fsrc;
        wr_acc                 = !dec.dest;
        wr_file                = dec.dest;
        next_flags.result_null = (next_result == 8'h00);
      end
      OP_SHIFT: begin
        next_result             = {fsrc[7], fsrc[7:1]};
        wr_acc                  = !dec.dest;
        wr_file                 = dec.dest;
        next_flags.overflow_out = fsrc[0];
        next_flags.result_null  = (next_result == 8'h00);
      end
      default: begin
        next_result = 8'h00;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Accumulator: instruction write wins over a side load
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc <= ACC_RST;
    end else if (exec_en && wr_acc) begin
      acc <= next_result;
    end else if (acc_load_i) begin
      acc <= acc_load_data_i;
    end
  end

  // Status flags change only on an executed instruction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= '0;
    end else if (exec_en) begin
      flags <= next_flags;
    end
  end

  // ------------------------------------------------------------------
  // File registers: one generate slice per location
  // ------------------------------------------------------------------
  for (genvar gi = 0; gi < FILE_N; gi++) begin : g_file
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        file_q[gi] <= FILE_RST;
      end else if (exec_en && wr_file && (dec.faddr == 7'(gi))) begin
        file_q[gi] <= next_result;
      end else if (file_load_i && (file_load_addr_i == 7'(gi))) begin
        file_q[gi] <= file_load_data_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Indirect pointers: 16-bit add wraps on its own
  // ------------------------------------------------------------------
  for (genvar gp = 0; gp < PTR_N; gp++) begin : g_ptr
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        indirect_pointer[gp] <= PTR_RST;
      end else if (exec_en && (dec.op == OP_PTR_ADD) && (dec.ptr_sel == 1'(gp))) begin
        indirect_pointer[gp] <= indirect_pointer[gp] + ptr_off;
      end else if (ptr_load_i && (ptr_load_sel_i == 1'(gp))) begin
        indirect_pointer[gp] <= ptr_load_data_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Completion, illegal-word report and file peek
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done    <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done    <= exec_en;
      illegal <= instr_valid_i && (dec.op == OP_NONE);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      file_peek <= FILE_RST;
    end else begin
      file_peek <= file_q[file_peek_addr_i];
    end
  end

  // Outputs straight from the flip-flops
  assign acc_o               = acc;
  assign flags_o             = flags;
  assign indirect_pointer0_o = indirect_pointer[0];
  assign indirect_pointer1_o = indirect_pointer[1];
  assign file_peek_o         = file_peek;
  assign done_o              = done;
  assign illegal_o           = illegal;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ptr_issue;
    exec_en && dec.op == OP_PTR_ADD;
  endsequence

  sequence s_file_op;
    exec_en && (dec.op inside {OP_REG_SUM, OP_REG_SUM_C, OP_REG_MASK, OP_SHIFT});
  endsequence

  sequence s_shift_issue;
    exec_en && dec.op == OP_SHIFT;
  endsequence

  a_ptr_wrap_add: assert property (
    s_ptr_issue |=> indirect_pointer[$past(dec.ptr_sel)] ==
      16'($past(indirect_pointer[dec.ptr_sel]) + {{10{$past(dec.off[5])}}, $past(dec.off)}))
    else $error("pointer add result wrong");

  // A side load may still move the accumulator beside a pointer add
  a_ptr_flags_hold: assert property (
    s_ptr_issue |=> $stable(flags) && ($past(acc_load_i) || $stable(acc)))
    else $error("pointer add touched flags or accumulator");

  a_lit_sum_value: assert property (
    exec_en && dec.op == OP_LIT_SUM |=> acc == 8'($past(acc) + $past(dec.lit)))
    else $error("literal sum wrong");

  a_sum_carry_out: assert property (
    exec_en && dec.op == OP_REG_SUM |=>
      flags.overflow_out == (({1'b0, $past(acc)} + {1'b0, $past(fsrc)}) > 9'h0FF))
    else $error("register sum carry wrong");

  a_dest_to_file: assert property (
    s_file_op ##0 dec.dest |=> ($past(acc_load_i) || $stable(acc)) &&
      file_q[$past(dec.faddr)] == $past(next_result))
    else $error("result not routed to file register");

  a_dest_to_acc: assert property (
    s_file_op ##0 !dec.dest |=> acc == $past(next_result))
    else $error("result not routed to accumulator");

  a_sum_carry_in: assert property (
    exec_en && dec.op == OP_REG_SUM_C |-> next_result ==
      8'(acc + fsrc + {7'h00, flags.overflow_out}))
    else $error("sum with overflow wrong");

  a_mask_flags_only: assert property (
    exec_en && dec.op inside {OP_LIT_MASK, OP_REG_MASK} |=>
      $stable(flags.overflow_out) && $stable(flags.nibble_overflow_flag))
    else $error("mask changed carry flags");

  a_reg_mask_value: assert property (
    exec_en && dec.op == OP_REG_MASK |=>
      ($past(dec.dest) ? file_q[$past(dec.faddr)] : acc) == ($past(acc) & $past(fsrc)))
    else $error("register mask wrong");

  a_shift_sign_keep: assert property (
    s_shift_issue |=> flags.overflow_out == $past(fsrc[0]) &&
      (($past(dec.dest) ? file_q[$past(dec.faddr)] : acc) == {$past(fsrc[7]), $past(fsrc[7:1])}))
    else $error("signed shift wrong");

  a_done_one_cycle: assert property (
    instr_valid_i && instr_i[OPC_MSB:OPC_LSB] == OPC_PTR_ADD && !instr_i[PTR_ZB_BIT] |=>
      done_o && !illegal_o)
    else $error("pointer add did not complete in one cycle");

  // An undecoded word reports itself and leaves the flags alone
  a_illegal_quiet: assert property (
    instr_valid_i && dec.op == OP_NONE |=> illegal_o && !done_o && $stable(flags))
    else $error("undecoded word was executed");

  a_nibble_null: assert property (
    exec_en && dec.op inside {OP_LIT_SUM, OP_REG_SUM, OP_REG_SUM_C} |=>
      flags.nibble_overflow_flag == (({1'b0, $past(acc[3:0])} + {1'b0, $past(add_b[3:0])}
        + {4'h0, $past(add_cin)}) > 5'h0F) && flags.result_null == ($past(add.sum) == 8'h00))
    else $error("nibble or null flag wrong");

endmodule : aas_core

//--- pkg/aas_pkg.sv
// Package: constants, opcodes and carrier types for the add-and-shift datapath
package aas_pkg;

  // ------------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------------
  localparam int          WORD_W    = 14;
  localparam int          DATA_W    = 8;
  localparam int          PTR_W     = 16;
  localparam int          FILE_N    = 128;
  localparam int          PTR_N     = 2;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [7:0]  FILE_RST  = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;

  // ------------------------------------------------------------------
  // Instruction word fields
  // ------------------------------------------------------------------
  localparam int OPC_MSB    = 13;
  localparam int OPC_LSB    = 8;
  localparam int DEST_BIT   = 7;
  localparam int FADDR_MSB  = 6;
  localparam int LIT_MSB    = 7;
  localparam int PTR_ZB_BIT = 7;
  localparam int PTR_SEL    = 6;
  localparam int OFF_MSB    = 5;

  // ------------------------------------------------------------------
  // Major opcodes (bits 13:8)
  // ------------------------------------------------------------------
  localparam logic [5:0] OPC_PTR_ADD   = 6'h31;
  localparam logic [5:0] OPC_LIT_SUM   = 6'h3E;
  localparam logic [5:0] OPC_REG_SUM   = 6'h07;
  localparam logic [5:0] OPC_REG_SUM_C = 6'h3D;
  localparam logic [5:0] OPC_LIT_MASK  = 6'h39;
  localparam logic [5:0] OPC_REG_MASK  = 6'h05;
  localparam logic [5:0] OPC_SHIFT     = 6'h37;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_PTR_ADD, OP_LIT_SUM, OP_REG_SUM,
    OP_REG_SUM_C, OP_LIT_MASK, OP_REG_MASK, OP_SHIFT
  } aas_op_t;

  typedef struct packed {
    aas_op_t    op;
    logic       dest;
    logic [6:0] faddr;
    logic [7:0] lit;
    logic       ptr_sel;
    logic [5:0] off;
  } aas_instr_t;

  typedef struct packed {
    logic overflow_out;
    logic nibble_overflow_flag;
    logic result_null;
  } aas_flags_t;

  typedef struct packed {
    logic [7:0] sum;
    logic       carry;
    logic       half;
  } aas_sum_t;

endpackage : aas_pkg

//--- rtl/aas_decode.sv
// Instruction decoder: splits a 14-bit word into operation and operand fields
`timescale 1ns/10ps
module aas_decode (
  input  wire logic [aas_pkg::WORD_W-1:0] instr_i,
  output aas_pkg::aas_instr_t             dec_o
);
  import aas_pkg::*;

  logic [5:0] opc;

  assign opc = instr_i[OPC_MSB:OPC_LSB];

  // Operand fields are common to every format
  always_comb begin
    dec_o.dest    = instr_i[DEST_BIT];
    dec_o.faddr   = instr_i[FADDR_MSB:0];
    dec_o.lit     = instr_i[LIT_MSB:0];
    dec_o.ptr_sel = instr_i[PTR_SEL];
    dec_o.off     = instr_i[OFF_MSB:0];
    unique case (opc)
      OPC_PTR_ADD:   dec_o.op = instr_i[PTR_ZB_BIT] ? OP_NONE : OP_PTR_ADD;
      OPC_LIT_SUM:   dec_o.op = OP_LIT_SUM;
      OPC_REG_SUM:   dec_o.op = OP_REG_SUM;
      OPC_REG_SUM_C: dec_o.op = OP_REG_SUM_C;
      OPC_LIT_MASK:  dec_o.op = OP_LIT_MASK;
      OPC_REG_MASK:  dec_o.op = OP_REG_MASK;
      OPC_SHIFT:     dec_o.op = OP_SHIFT;
      default:       dec_o.op = OP_NONE;
    endcase
  end

endmodule : aas_decode

//--- rtl/aas_adder.sv
// Eight-bit adder with carry in, carry out and nibble carry
`timescale 1ns/10ps
module aas_adder (
  input  wire logic [7:0]   a_i,
  input  wire logic [7:0]   b_i,
  input  wire logic         cin_i,
  output aas_pkg::aas_sum_t res_o
);
  import aas_pkg::*;

  logic [4:0] low;
  logic [4:0] high;

  // Low nibble first so its carry is visible on its own
  assign low  = 5'({1'b0, a_i[3:0]}) + 5'({1'b0, b_i[3:0]}) + 5'(cin_i);
  assign high = 5'({1'b0, a_i[7:4]}) + 5'({1'b0, b_i[7:4]}) + 5'(low[4]);

  // Carry out of bit 3 is the nibble flag source
  assign res_o.sum   = {high[3:0], low[3:0]};
  assign res_o.carry = high[4];
  assign res_o.half  = low[4];

endmodule : aas_adder

//--- bench/tb_alu_add_and_shift_ops.sv
// Self-checking testbench for the add-and-shift execution datapath
`timescale 1ns/10ps
module tb_alu_add_and_shift_ops;
  import aas_pkg::*;

  // ------------------------------------------------------------------
  // Stimulus, reference state and counters
  // ------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        vld = 1'b0;
  logic [13:0] ins = 14'h0000;
  logic        al = 1'b0, fl = 1'b0, pl = 1'b0, psel = 1'b0;
  logic [7:0]  ad = 8'h00, fd = 8'h00;
  logic [6:0]  fa = 7'h00, pa = 7'h00;
  logic [15:0] pd = 16'h0000;
  logic [7:0]  acc_o, file_peek_o;
  aas_flags_t  flags_o;
  logic [15:0] p0_o, p1_o;
  logic        done_o, illegal_o;
  logic [7:0]  m_acc = ACC_RST;
  logic [2:0]  m_flg = 3'h0;
  logic [7:0]  m_file [128];
  logic [15:0] m_ptr [2];
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;

  aas_core dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(vld), .instr_i(ins),
    .acc_load_i(al), .acc_load_data_i(ad), .file_load_i(fl), .file_load_addr_i(fa),
    .file_load_data_i(fd), .ptr_load_i(pl), .ptr_load_sel_i(psel), .ptr_load_data_i(pd),
    .file_peek_addr_i(pa), .acc_o(acc_o), .flags_o(flags_o), .indirect_pointer0_o(p0_o),
    .indirect_pointer1_o(p1_o), .file_peek_o(file_peek_o), .done_o(done_o),
    .illegal_o(illegal_o)
  );

  // Clock and hang guard
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // Compare tasks and verdict
  // ------------------------------------------------------------------
  task automatic chk1(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask : chk1
  task automatic chk3(input string n, input logic [2:0] e, input logic [2:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk3
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk8
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk16
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // Drivers: side loads, reference step, instruction issue
  // ------------------------------------------------------------------
  task automatic load(input int k, input logic [6:0] a, input logic [15:0] v);
    @(posedge clk_i);
    al <= (k == 0);
    fl <= (k == 1);
    pl <= (k == 2);
    ad <= v[7:0];
    fd <= v[7:0];
    fa <= a;
    psel <= a[0];
    pd <= v;
    @(posedge clk_i);
    {al, fl, pl} <= 3'b000;
    if (k == 0) m_acc = v[7:0];
    else if (k == 1) m_file[a] = v[7:0];
    else m_ptr[a[0]] = v;
  endtask : load

  // Reference step built from the operation definitions
  task automatic step(input logic [13:0] w);
    logic [5:0] o;
    logic [7:0] f, b, r;
    logic [8:0] s;
    logic       ci, hc, wr;
    o = w[13:8];
    f = m_file[w[6:0]];
    b = (o == OPC_LIT_SUM || o == OPC_LIT_MASK) ? w[7:0] : f;
    wr = w[7] && !(o == OPC_LIT_SUM || o == OPC_LIT_MASK);
    ci = (o == OPC_REG_SUM_C) ? m_flg[2] : 1'b0;
    s = m_acc + b + ci;
    hc = ({1'b0, m_acc[3:0]} + b[3:0] + ci) > 5'h0F;
    if (o == OPC_PTR_ADD) begin
      m_ptr[w[6]] = m_ptr[w[6]] + {{10{w[5]}}, w[5:0]};
      return;
    end
    if (o == OPC_LIT_MASK || o == OPC_REG_MASK) r = m_acc & b;
    else if (o == OPC_SHIFT) r = {f[7], f[7:1]};
    else r = s[7:0];
    if (o == OPC_SHIFT) m_flg[2] = f[0];
    else if (o != OPC_LIT_MASK && o != OPC_REG_MASK) m_flg[2:1] = {s[8], hc};
    m_flg[0] = (r == 8'h00);
    if (wr) m_file[w[6:0]] = r;
    else m_acc = r;
  endtask : step

  // Issue one word, then compare every output and the addressed file register
  task automatic exec(input logic [13:0] w, input logic ok);
    @(posedge clk_i);
    vld <= 1'b1;
    ins <= w;
    pa <= w[6:0];
    @(posedge clk_i);
    vld <= 1'b0;
    #1;
    if (ok) step(w);
    chk1("done", ok, done_o);
    chk1("illegal", !ok, illegal_o);
    chk8("acc", m_acc, acc_o);
    chk3("flags", m_flg, flags_o);
    chk16("ptr0", m_ptr[0], p0_o);
    chk16("ptr1", m_ptr[1], p1_o);
    @(posedge clk_i);
    #1;
    chk8("file", m_file[w[6:0]], file_peek_o);
  endtask : exec

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic s_pointer();
    load(0, 7'h00, 16'h00FF);
    exec({OPC_LIT_SUM, 8'h01}, 1'b1);
    load(2, 7'h00, 16'hFFFE);
    exec({OPC_PTR_ADD, 2'b00, 6'h1F}, 1'b1);
    load(2, 7'h01, 16'h0005);
    exec({OPC_PTR_ADD, 2'b01, 6'h20}, 1'b1);
    exec({OPC_PTR_ADD, 2'b11, 6'h3F}, 1'b0);
  endtask : s_pointer

  task automatic s_sums();
    load(0, 7'h00, 16'h000F);
    exec({OPC_LIT_SUM, 8'h01}, 1'b1);
    exec({OPC_LIT_SUM, 8'hFF}, 1'b1);
    load(1, 7'h7F, 16'h0080);
    exec({OPC_REG_SUM, 1'b0, 7'h7F}, 1'b1);
    exec({OPC_REG_SUM, 1'b1, 7'h7F}, 1'b1);
    load(1, 7'h05, 16'h000E);
    exec({OPC_REG_SUM_C, 1'b1, 7'h05}, 1'b1);
    exec({OPC_REG_SUM_C, 1'b0, 7'h05}, 1'b1);
  endtask : s_sums

  task automatic s_masks();
    load(0, 7'h00, 16'h00A5);
    exec({OPC_LIT_MASK, 8'h0F}, 1'b1);
    load(1, 7'h09, 16'h00F0);
    exec({OPC_REG_MASK, 1'b1, 7'h09}, 1'b1);
    exec({OPC_REG_MASK, 1'b0, 7'h09}, 1'b1);
  endtask : s_masks

  task automatic s_shift();
    load(1, 7'h03, 16'h0081);
    exec({OPC_SHIFT, 1'b0, 7'h03}, 1'b1);
    load(1, 7'h04, 16'h007E);
    exec({OPC_SHIFT, 1'b1, 7'h04}, 1'b1);
    load(1, 7'h06, 16'h0001);
    exec({OPC_SHIFT, 1'b1, 7'h06}, 1'b1);
  endtask : s_shift

  // Two words on consecutive edges; the second sees the first's sum
  task automatic s_back_to_back();
    load(0, 7'h00, 16'h0040);
    @(posedge clk_i);
    vld <= 1'b1;
    ins <= {OPC_LIT_SUM, 8'h30};
    @(posedge clk_i);
    ins <= {OPC_LIT_SUM, 8'h50};
    @(posedge clk_i);
    vld <= 1'b0;
    #1;
    step({OPC_LIT_SUM, 8'h30});
    step({OPC_LIT_SUM, 8'h50});
    chk1("done", 1'b1, done_o);
    chk8("acc", m_acc, acc_o);
    chk3("flags", m_flg, flags_o);
  endtask : s_back_to_back

  // Reset in mid-run: all state returns to its reset value at once
  task automatic s_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk8("rst acc", ACC_RST, acc_o);
    chk3("rst flags", 3'h0, flags_o);
    chk16("rst ptr0", PTR_RST, p0_o);
    chk16("rst ptr1", PTR_RST, p1_o);
    chk1("rst done", 1'b0, done_o);
    chk1("rst illegal", 1'b0, illegal_o);
    chk8("rst file", FILE_RST, file_peek_o);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    m_acc = ACC_RST;
    m_flg = 3'h0;
    for (int i = 0; i < 128; i++) m_file[i] = FILE_RST;
    m_ptr[0] = PTR_RST;
    m_ptr[1] = PTR_RST;
    exec({OPC_LIT_SUM, 8'h00}, 1'b1);
  endtask : s_reset

  // Main sequence
  initial begin
    for (int i = 0; i < 128; i++) m_file[i] = FILE_RST;
    m_ptr[0] = PTR_RST;
    m_ptr[1] = PTR_RST;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_pointer();
    s_sums();
    s_masks();
    s_shift();
    s_reset();
    s_back_to_back();
    complete_run();
  end

endmodule : tb_alu_add_and_shift_ops
